/* File: logic/alert_cfg.v */
// SMBus slave holding configuration registers 1 and 2 and the alert output
//
// Contract
// - Writing one to bit 7 of config register two resets the device and the bit self-clears.
// - The soft-reset bit always reads back as zero.
// - Soft reset acts at the bus clock rise of the data LSB and that byte is not acknowledged.
// - Bit 6 enables the low-supply interrupt, default zero.
// - Bit 5 gates the remote over-limit flag onto the interrupt.
// - Bit 5 powers up as one unless a remote sensor failure is seen at power-on.
// - Bit 4 gates the local over-limit flag onto the interrupt, default one.
// - Config register two sits at address 0x01 and resets to 0x3D.
// - Every enabled interrupt drives the bus alert output.
// - The master alert enable in config register one must also be set; it defaults to zero.
`timescale 1ns/1ps
`include "alert_consts.vh"
module alert_cfg #(
  parameter [6:0] DEV_ADDR = `SMB_DEV_ADDR
) (
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe,
  output reg sda_out,
  output reg alert_n,
  output reg soft_reset_pulse,
  input wire low_supply_flag,
  input wire remote_over_limit_flag,
  input wire local_over_limit_flag,
  input wire remote_fail_at_power_on
);
  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;
  edge_sync scl_sync (.clk(clk), .rst(rst), .din(scl_in), .level(scl_lvl),
    .rise(scl_rise), .fall(scl_fall));
  edge_sync sda_sync (.clk(clk), .rst(rst), .din(sda_in), .level(sda_lvl),
    .rise(sda_rise), .fall(sda_fall));
  wire start_cond = sda_fall & scl_lvl;
  wire stop_cond = sda_rise & scl_lvl;

  // ****************************************************
  // Protocol engine
  // ****************************************************
  // One-hot states; a stray code falls back to idle
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RX = 5'h02;
  localparam [4:0] S_ACK = 5'h04;
  localparam [4:0] S_TX = 5'h08;
  localparam [4:0] S_TXACK = 5'h10;

  reg [4:0] state_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_cnt_reg;
  reg [1:0] byte_idx_reg;
  reg rd_reg;
  reg ack_ok_reg;
  reg [7:0] ptr_reg;
  reg [7:0] cfg1_reg;
  reg [7:0] cfg2_reg;
  reg first_reg;
  reg boot_reg;

  // ****************************************************
  // Register view
  // ****************************************************
  // Reset bit is never stored, so readback is zero by construction
  wire [7:0] cfg2_view = {1'b0, cfg2_reg[6:0]};
  wire [7:0] rd_data = (ptr_reg == `CFG2_ADDR) ? cfg2_view :
    (ptr_reg == `CFG1_ADDR) ? cfg1_reg : 8'h00;
  wire [7:0] rx_byte = {shift_reg[6:0], sda_lvl};
  wire addr_match = (shift_reg[7:1] == DEV_ADDR);

  // ****************************************************
  // Soft reset decode
  // ****************************************************
  // Soft reset is decided on the LSB rise, before any acknowledge is driven
  wire soft_hit = (state_reg == S_RX) && scl_rise && (bit_cnt_reg == 4'h7) &&
    (byte_idx_reg == 2'h2) && (ptr_reg == `CFG2_ADDR) &&
    rx_byte[`CFG2_SOFT_RST_BIT];

  // ****************************************************
  // Bus and register state
  // ****************************************************
  always @(posedge clk) begin
    if (rst || soft_hit) begin
      state_reg <= S_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
      rd_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      ptr_reg <= 8'h00;
      cfg1_reg <= `CFG1_RESET;
      cfg2_reg <= `CFG2_RESET;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      first_reg <= 1'b1;
      boot_reg <= rst;
      soft_reset_pulse <= soft_hit & ~rst;
    end else begin
      soft_reset_pulse <= 1'b0;
      first_reg <= 1'b0;
      // Strap sampled on the first cycle after power-on release only
      if (first_reg && boot_reg && remote_fail_at_power_on) begin
        cfg2_reg[`CFG2_REMOTE_BIT] <= 1'b0;
      end
      if (start_cond) begin
        state_reg <= S_RX;
        bit_cnt_reg <= 4'h0;
        byte_idx_reg <= 2'h0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            sda_oe <= 1'b0;
          end
          S_RX: begin
            if (scl_rise) begin
              shift_reg <= rx_byte;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              state_reg <= S_ACK;
              ack_ok_reg <= 1'b1;
              if (byte_idx_reg == 2'h0) begin
                ack_ok_reg <= addr_match;
                rd_reg <= shift_reg[0];
              end else if (byte_idx_reg == 2'h1) begin
                ptr_reg <= shift_reg;
              end else if (ptr_reg == `CFG2_ADDR) begin
                cfg2_reg <= {1'b0, shift_reg[6:0]};
              end else if (ptr_reg == `CFG1_ADDR) begin
                cfg1_reg <= shift_reg;
              end
              sda_oe <= (byte_idx_reg == 2'h0) ? addr_match : 1'b1;
              sda_out <= 1'b0;
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              if (!ack_ok_reg) begin
                state_reg <= S_IDLE;
                sda_oe <= 1'b0;
              end else if (rd_reg) begin
                state_reg <= S_TX;
                shift_reg <= {rd_data[6:0], 1'b0};
                sda_oe <= ~rd_data[7];
                bit_cnt_reg <= 4'h1;
              end else begin
                state_reg <= S_RX;
                sda_oe <= 1'b0;
                if (byte_idx_reg != 2'h2) begin
                  byte_idx_reg <= byte_idx_reg + 2'h1;
                end
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                state_reg <= S_TXACK;
                sda_oe <= 1'b0;
              end else begin
                sda_oe <= ~shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          S_TXACK: begin
            // Host NACK ends the read; ACK re-sends the same register
            if (scl_rise) begin
              ack_ok_reg <= ~sda_lvl;
            end
            if (scl_fall) begin
              if (ack_ok_reg) begin
                state_reg <= S_TX;
                shift_reg <= {rd_data[6:0], 1'b0};
                sda_oe <= ~rd_data[7];
                bit_cnt_reg <= 4'h1;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************
  // Alert output
  // ****************************************************
  wire low_supply_term = low_supply_flag & cfg2_reg[`CFG2_LOW_SUPPLY_BIT];
  wire remote_term = remote_over_limit_flag & cfg2_reg[`CFG2_REMOTE_BIT];
  wire local_term = local_over_limit_flag & cfg2_reg[`CFG2_LOCAL_BIT];
  wire any_irq = low_supply_term | remote_term | local_term;
  // Registered so the pin cannot glitch while flags and enables settle

  always @(posedge clk) begin
    if (rst) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~(any_irq & cfg1_reg[`CFG1_MASTER_EN_BIT]);
    end
  end
endmodule

/* File: logic/alert_consts.vh */
// Constants for the alert-enable and soft-reset register block
`ifndef ALERT_CONSTS_VH
`define ALERT_CONSTS_VH
`define CFG2_ADDR 8'h01
`define CFG1_ADDR 8'h00
`define CFG2_RESET 8'h3D
`define CFG1_RESET 8'hD4
`define CFG2_RESET_NO_REMOTE 8'h1D
`define CFG1_MASTER_EN_BIT 1
`define CFG2_SOFT_RST_BIT 7
`define CFG2_LOW_SUPPLY_BIT 6
`define CFG2_REMOTE_BIT 5
`define CFG2_LOCAL_BIT 4
`define SMB_DEV_ADDR 7'h18
`endif

/* File: logic/edge_sync.v */
// Two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
module edge_sync (
  input wire clk,
  input wire rst,
  input wire din,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule

/* File: sim/alert_cfg_sva.sv */
// Concurrent checks on the alert and soft-reset register block
`timescale 1ns/1ps
module alert_cfg_sva (
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  input wire sda_oe,
  input wire sda_out,
  input wire alert_n,
  input wire soft_reset_pulse,
  input wire low_supply_flag,
  input wire remote_over_limit_flag,
  input wire local_over_limit_flag,
  input wire remote_fail_at_power_on
);
  wire any_flag = low_supply_flag | remote_over_limit_flag | local_over_limit_flag;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ************
  // Assertions
  // ************
  a_quiet_no_flag: assert property (!any_flag |=> alert_n)
    else $error("alert low with no flag");
  a_alert_cause: assert property ($fell(alert_n) |-> $past(any_flag))
    else $error("alert fell without a flag");
  a_pulse_once: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  a_reset_no_ack: assert property (soft_reset_pulse |=> !sda_oe [*8])
    else $error("ack after soft reset");
  a_reset_masks: assert property (soft_reset_pulse |-> ##2 alert_n [*4])
    else $error("alert not masked after soft reset");
  a_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("data driven high");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data driven while clock high");
  a_oe_bounded: assert property (sda_oe |-> ##[0:80] !sda_oe)
    else $error("data line held too long");
  // Main scenarios
  c_pulse: cover property (soft_reset_pulse);
  c_alert: cover property ($fell(alert_n));
  c_ack: cover property ($rose(sda_oe));
endmodule

/* File: sim/smb_host.sv */
// SMBus host model: clock idles high between frames, data is open drain
`timescale 1ns/1ps
module smb_host (
  input wire clk,
  input wire sda,
  output reg scl,
  output reg sda_h
);
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  // Eight clk per bit keeps the 320 ns bus period
  task automatic hc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tx(input logic b, output logic r);
    sda_h = b;
    hc(2);
    scl = 1'b1;
    hc(2);
    r = sda;
    hc(2);
    scl = 1'b0;
    hc(2);
  endtask
  task automatic start;
    sda_h = 1'b1;
    hc(2);
    scl = 1'b1;
    hc(2);
    sda_h = 1'b0;
    hc(2);
    scl = 1'b0;
    hc(2);
  endtask
  task automatic stop;
    sda_h = 1'b0;
    hc(2);
    scl = 1'b1;
    hc(2);
    sda_h = 1'b1;
    hc(2);
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) tx(d[i], r);
    tx(1'b1, r);
    ack = !r;
  endtask
  // Host ends every read with a not-acknowledge
  task automatic rb(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) tx(1'b1, d[i]);
    tx(1'b1, r);
  endtask
endmodule

/* File: sim/tb.sv */
// Testbench for the alert enable and soft-reset register block
`timescale 1ns/1ps
`include "alert_consts.vh"
module tb;
  reg clk;
  reg rst;
  reg [2:0] flg;
  reg strap;
  wire scl, sda_h, sda_oe, sda_out, alert_n, soft_reset_pulse;
  wire sda = sda_h & (!sda_oe | sda_out);
  int n_mismatch = 0;
  int checked = 0;
  int n_pulse = 0;
  logic [7:0] v;
  logic a;
  smb_host h (.clk(clk), .sda(sda), .scl(scl), .sda_h(sda_h));
  alert_cfg uut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_oe(sda_oe),
    .sda_out(sda_out), .alert_n(alert_n), .soft_reset_pulse(soft_reset_pulse),
    .low_supply_flag(flg[2]), .remote_over_limit_flag(flg[1]),
    .local_over_limit_flag(flg[0]), .remote_fail_at_power_on(strap));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (soft_reset_pulse === 1'b1) n_pulse++;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d, output logic ak);
    h.start;
    h.wb({`SMB_DEV_ADDR, 1'b0}, ak);
    h.wb(ad, ak);
    h.wb(d, ak);
    h.stop;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    logic ak;
    h.start;
    h.wb({`SMB_DEV_ADDR, 1'b0}, ak);
    h.wb(ad, ak);
    h.start;
    h.wb({`SMB_DEV_ADDR, 1'b1}, ak);
    h.rb(d);
    h.stop;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    rst = 1'b1;
    flg = 3'h0;
    strap = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    h.hc(4);
    rd(`CFG2_ADDR, v);
    chk("cfg2", 8'h3D, v);
    rd(`CFG1_ADDR, v);
    chk("cfg1", 8'hD4, v);
    flg = 3'h7;
    h.hc(3);
    chk("alert_n", 8'h01, {7'h0, alert_n});
    wr(`CFG1_ADDR, 8'hD6, a);
    chk("ack", 8'h01, {7'h0, a});
    for (int i = 0; i < 3; i++) begin
      wr(`CFG2_ADDR, 8'h10 << i, a);
      rd(`CFG2_ADDR, v);
      chk("cfg2", 8'h10 << i, v);
      flg = 3'h1 << i;
      h.hc(3);
      chk("alert_n", 8'h00, {7'h0, alert_n});
      flg = ~(3'h1 << i);
      h.hc(3);
      chk("alert_n", 8'h01, {7'h0, alert_n});
    end
    wr(`CFG2_ADDR, 8'hF0, a);
    chk("ack", 8'h00, {7'h0, a});
    chk("pulses", 8'h01, n_pulse[7:0]);
    rd(`CFG2_ADDR, v);
    chk("cfg2", 8'h3D, v);
    rd(`CFG1_ADDR, v);
    chk("cfg1", 8'hD4, v);
    chk("alert_n", 8'h01, {7'h0, alert_n});
    rst = 1'b1;
    strap = 1'b1;
    h.hc(4);
    rst = 1'b0;
    h.hc(4);
    strap = 1'b0;
    rd(`CFG2_ADDR, v);
    chk("cfg2", `CFG2_RESET_NO_REMOTE, v);
    stop_test;
  end
endmodule
bind alert_cfg alert_cfg_sva chk_i (.clk, .rst, .scl_in, .sda_in, .sda_oe, .sda_out, .alert_n,
  .soft_reset_pulse, .low_supply_flag, .remote_over_limit_flag, .local_over_limit_flag,
  .remote_fail_at_power_on);
